// ===== rtl/image_sensor_readout_control.sv
`timescale 1ns/1ps

// What this block does
// - chip init low returns every control register to its reset value.
// - power save input low stops the readout and enters power saving.
// - line freeze low holds the current row; high resumes row progress.
// - in single frame mode the trigger starts and stops integration.
// - ten-bit pixel bus; unused low bits zero at reduced resolution.
// - pixel clock output at divide by 2, 4 or 8 lets the host sample each pixel word.
// - horizontal output is sync pulse or pixel valid per mode.
// - vertical output is sync pulse or line valid per mode.
// - serial slave port, clock input and open-drain data line.
// - mode A bit 5 enables bad pixel replacement, off at reset.
// - mode A bit 4 selects auto dark compensation, manual at reset.
// - mode A bit 3 separates colour channel handling, shared at reset.
// - mode A bit 2 enables electronic shutter, off at reset.
// - mode A bits 1:0 select 8, 9 or 10 bit conversion.
// - mode B bits 7 and 6 mirror vertically and horizontally.
// - mode B bits 5:4 divide pixel clock by 1, 2, 4 or 8.
// - mode B row and column subsampling: off, 2, 3 or 4.
// - 9-bit window first row from two registers, resets to 14.
// - 9-bit window first column from two registers, resets to 14.
// - 9-bit window row count from two registers, resets to 480.
// - 10-bit window column count from two registers, resets to 640.
// - factory analog offset reference byte resets to 128.
module image_sensor_readout_control
  import sensor_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       chipInitN,
  input  wire logic       powerSaveN,
  input  wire logic       lineFreezeN,
  input  wire logic       integrationTrigger,
  input  wire logic       singleFrameMode,
  input  wire logic       hDataValidMode,
  input  wire logic       vLineValidMode,
  input  wire logic [9:0] pixelIn,
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaDriveN,
  output logic [9:0]      pixelBus,
  output logic            pixelClockOut,
  output logic            hSyncOut,
  output logic            vSyncOut,
  output logic [9:0]      arrayRow,
  output logic [9:0]      arrayCol,
  output logic            badPixelEn,
  output logic            darkAutoEn,
  output logic            chanSeparateEn,
  output logic            shutterEn,
  output logic [7:0]      analogOffsetRef,
  output logic            powerSaving,
  output logic            integrating
);
  import sensor_pkg::*;

  typedef struct packed {
    logic [1:0]                initSync;
    logic [1:0]                saveSync;
    logic [1:0]                freezeSync;
    logic [1:0]                trigSync;
    logic [1:0]                sclSync;
    logic [1:0]                sdaSync;
    logic                      sclPrev;
    logic                      sdaPrev;
    logic                      trigPrev;
    i2c_state_e                i2cState;
    logic [3:0]                bitCnt;
    logic [7:0]                shift;
    logic [1:0]                byteKind;
    logic                      readMode;
    logic [7:0]                regPtr;
    logic                      sdaDrive;
    logic [NUM_REGS-1:0][7:0]  regs;
    logic [2:0]                divCnt;
    logic                      pixClk;
    logic [9:0]                colOff;
    logic [7:0]                hBlankCnt;
    logic                      lineActive;
    logic [8:0]                rowOff;
    logic [5:0]                vBlankCnt;
    logic                      frameActive;
    logic [9:0]                pixelData;
    logic                      hOut;
    logic                      vOut;
    logic                      integ;
  } state_s;

  state_s st_reg;
  state_s st_next;

  // subsampling step from a two-bit code
  function automatic logic [2:0] subStep(input logic [1:0] code);
    return {1'h0, code} + 3'h1;
  endfunction

  // last divider count for a clock code
  function automatic logic [2:0] divLast(input logic [1:0] code);
    logic [2:0] last;
    last = 3'h0;
    unique case (code)
      2'h0: last = 3'h0;
      2'h1: last = 3'h1;
      2'h2: last = 3'h3;
      2'h3: last = 3'h7;
    endcase
    return last;
  endfunction

  // mask clearing unused low bits
  function automatic logic [9:0] adcMask(input logic [1:0] code);
    logic [9:0] m;
    m = 10'h3FF;
    if (code == ADC_8BIT) begin
      m = 10'h3FC;
    end else if (code == ADC_9BIT) begin
      m = 10'h3FE;
    end
    return m;
  endfunction

  logic        sclRise;
  logic        sclFall;
  logic        startCond;
  logic        stopCond;
  logic        trigRise;
  logic        trigFall;
  logic [1:0]  adcRes;
  logic [1:0]  divCode;
  logic [2:0]  lastCnt;
  logic        pixTick;
  logic        lineEndTick;
  logic [2:0]  colStep;
  logic [2:0]  rowStep;
  logic [8:0]  wrp;
  logic [8:0]  wcp;
  logic [8:0]  wrd;
  logic [9:0]  wcw;
  logic [10:0] colSum;
  logic [9:0]  rowSum;
  logic [7:0]  rdByte;
  logic [10:0] rowFwd;
  logic [10:0] rowRev;
  logic [10:0] colFwd;
  logic [10:0] colRev;
  logic        pixValid;

  // serial line and trigger events from the synchronised copies
  assign sclRise   = st_reg.sclSync[1] & ~st_reg.sclPrev;
  assign sclFall   = ~st_reg.sclSync[1] & st_reg.sclPrev;
  assign startCond = st_reg.sclSync[1] & st_reg.sclPrev & st_reg.sdaPrev & ~st_reg.sdaSync[1];
  assign stopCond  = st_reg.sclSync[1] & st_reg.sclPrev & ~st_reg.sdaPrev & st_reg.sdaSync[1];
  assign trigRise  = st_reg.trigSync[1] & ~st_reg.trigPrev;
  assign trigFall  = ~st_reg.trigSync[1] & st_reg.trigPrev;

  // field decode of the mode registers and the register pairs
  assign adcRes  = st_reg.regs[IDX_MODE_A][ADC_LSB+:2];
  assign divCode = st_reg.regs[IDX_MODE_B][DIV_LSB+:2];
  assign colStep = subStep(st_reg.regs[IDX_MODE_B][SUBC_LSB+:2]);
  assign rowStep = subStep(st_reg.regs[IDX_MODE_B][SUBR_LSB+:2]);
  assign wrp = {st_reg.regs[IDX_ROW_START_HI][0], st_reg.regs[IDX_ROW_START_LO]};
  assign wcp = {st_reg.regs[IDX_COL_START_HI][0], st_reg.regs[IDX_COL_START_LO]};
  assign wrd = {st_reg.regs[IDX_ROWS_HI][0], st_reg.regs[IDX_ROWS_LO]};
  assign wcw = {st_reg.regs[IDX_COLS_HI][1:0], st_reg.regs[IDX_COLS_LO]};

  // pixel tick and line bookkeeping
  assign lastCnt     = divLast(divCode);
  assign pixTick     = st_reg.divCnt >= lastCnt;
  assign pixValid    = st_reg.lineActive & st_reg.frameActive;
  assign lineEndTick = pixTick & ~st_reg.lineActive & (st_reg.hBlankCnt == HBLANK_LAST);
  assign colSum      = {1'h0, st_reg.colOff} + {8'h00, colStep};
  assign rowSum      = {1'h0, st_reg.rowOff} + {7'h00, rowStep};
  assign rdByte      = (st_reg.regPtr < REG_COUNT) ? st_reg.regs[st_reg.regPtr[3:0]] : 8'h00;

  // array addresses with mirroring
  assign rowFwd = {2'h0, wrp} + {2'h0, st_reg.rowOff};
  assign rowRev = {2'h0, wrp} + {2'h0, wrd} - 11'h001 - {2'h0, st_reg.rowOff};
  assign colFwd = {2'h0, wcp} + {1'h0, st_reg.colOff};
  assign colRev = {2'h0, wcp} + {1'h0, wcw} - 11'h001 - {1'h0, st_reg.colOff};
  assign arrayRow = st_reg.regs[IDX_MODE_B][MIRV_BIT] ? rowRev[9:0] : rowFwd[9:0];
  assign arrayCol = st_reg.regs[IDX_MODE_B][MIRH_BIT] ? colRev[9:0] : colFwd[9:0];

  // next state of the whole block
  always_comb begin
    st_next = st_reg;
    st_next.initSync   = {st_reg.initSync[0], chipInitN};
    st_next.saveSync   = {st_reg.saveSync[0], powerSaveN};
    st_next.freezeSync = {st_reg.freezeSync[0], lineFreezeN};
    st_next.trigSync   = {st_reg.trigSync[0], integrationTrigger};
    st_next.sclSync    = {st_reg.sclSync[0], sclIn};
    st_next.sdaSync    = {st_reg.sdaSync[0], sdaIn};
    st_next.sclPrev    = st_reg.sclSync[1];
    st_next.sdaPrev    = st_reg.sdaSync[1];
    st_next.trigPrev   = st_reg.trigSync[1];

    // serial slave: address, pointer, data with auto increment
    if (startCond) begin
      st_next.i2cState = I2C_RX;
      st_next.bitCnt   = 4'h0;
      st_next.byteKind = 2'h0;
      st_next.sdaDrive = 1'b0;
    end else if (stopCond) begin
      st_next.i2cState = I2C_IDLE;
      st_next.sdaDrive = 1'b0;
    end else begin
      unique case (st_reg.i2cState)
        I2C_IDLE: begin
          st_next.sdaDrive = 1'b0;
        end
        I2C_RX: begin
          if (sclRise) begin
            st_next.shift  = {st_reg.shift[6:0], st_reg.sdaSync[1]};
            st_next.bitCnt = st_reg.bitCnt + 4'h1;
          end else if (sclFall && st_reg.bitCnt == 4'h8) begin
            st_next.i2cState = I2C_ACK;
            st_next.sdaDrive = 1'b1;
            if (st_reg.byteKind == 2'h0) begin
              st_next.readMode = st_reg.shift[0];
              if (st_reg.shift[7:1] != DEVICE_ADDR) begin
                st_next.i2cState = I2C_IDLE;
                st_next.sdaDrive = 1'b0;
              end
            end else if (st_reg.byteKind == 2'h1) begin
              st_next.regPtr = st_reg.shift;
            end else begin
              if (st_reg.regPtr < REG_COUNT) begin
                st_next.regs[st_reg.regPtr[3:0]] = st_reg.shift & REG_MASK[st_reg.regPtr[3:0]];
              end
              st_next.regPtr = st_reg.regPtr + 8'h01;
            end
          end
        end
        I2C_ACK: begin
          if (sclFall) begin
            st_next.bitCnt = 4'h0;
            if (st_reg.byteKind == 2'h0 && st_reg.readMode) begin
              st_next.i2cState = I2C_TX;
              st_next.shift    = rdByte;
              st_next.regPtr   = st_reg.regPtr + 8'h01;
              st_next.sdaDrive = ~rdByte[7];
            end else begin
              st_next.i2cState = I2C_RX;
              st_next.sdaDrive = 1'b0;
              st_next.byteKind = (st_reg.byteKind == 2'h0) ? 2'h1 : 2'h2;
            end
          end
        end
        I2C_TX: begin
          if (sclFall) begin
            if (st_reg.bitCnt == 4'h7) begin
              st_next.i2cState = I2C_TACK;
              st_next.sdaDrive = 1'b0;
            end else begin
              st_next.bitCnt   = st_reg.bitCnt + 4'h1;
              st_next.shift    = {st_reg.shift[6:0], 1'b0};
              st_next.sdaDrive = ~st_reg.shift[6];
            end
          end
        end
        I2C_TACK: begin
          if (sclRise) begin
            if (st_reg.sdaSync[1]) begin
              st_next.i2cState = I2C_IDLE;
            end else begin
              st_next.bitCnt = 4'h8;
            end
          end else if (sclFall && st_reg.bitCnt == 4'h8) begin
            st_next.i2cState = I2C_TX;
            st_next.bitCnt   = 4'h0;
            st_next.shift    = rdByte;
            st_next.regPtr   = st_reg.regPtr + 8'h01;
            st_next.sdaDrive = ~rdByte[7];
          end
        end
      endcase
    end

    // chip init pin restores all registers
    if (!st_reg.initSync[1]) begin
      st_next.regs     = REG_RESET;
      st_next.i2cState = I2C_IDLE;
      st_next.sdaDrive = 1'b0;
      st_next.regPtr   = 8'h00;
    end

    // pixel clock divider
    st_next.divCnt = pixTick ? 3'h0 : st_reg.divCnt + 3'h1;
    st_next.pixClk = (lastCnt == 3'h0) ? 1'b1 : (st_next.divCnt > (lastCnt >> 1));

    // timing generator, one step per pixel tick
    if (pixTick) begin
      st_next.pixelData = pixValid ? (pixelIn & adcMask(adcRes)) : 10'h000;
      st_next.hOut = hDataValidMode ? pixValid
                   : (~st_reg.lineActive & (st_reg.hBlankCnt < HSYNC_TICKS));
      st_next.vOut = vLineValidMode ? st_reg.frameActive
                   : (~st_reg.frameActive & (st_reg.vBlankCnt < VSYNC_LINES));
      if (st_reg.lineActive) begin
        st_next.colOff = colSum[9:0];
        if (colSum >= {1'h0, wcw}) begin
          st_next.lineActive = 1'b0;
          st_next.hBlankCnt  = 8'h00;
        end
      end else if (lineEndTick) begin
        st_next.lineActive = 1'b1;
        st_next.colOff     = 10'h000;
        if (st_reg.frameActive) begin
          if (st_reg.freezeSync[1]) begin
            st_next.rowOff = rowSum[8:0];
            if (rowSum >= {1'h0, wrd}) begin
              st_next.frameActive = 1'b0;
              st_next.vBlankCnt   = 6'h00;
            end
          end
        end else if (st_reg.vBlankCnt == VBLANK_LAST) begin
          st_next.frameActive = 1'b1;
          st_next.rowOff      = 9'h000;
        end else begin
          st_next.vBlankCnt = st_reg.vBlankCnt + 6'h01;
        end
      end else begin
        st_next.hBlankCnt = st_reg.hBlankCnt + 8'h01;
      end
    end

    // power saving halts readout and clears outputs
    if (!st_reg.saveSync[1]) begin
      st_next.divCnt      = 3'h0;
      st_next.pixClk      = 1'b0;
      st_next.lineActive  = 1'b0;
      st_next.frameActive = 1'b0;
      st_next.colOff      = 10'h000;
      st_next.rowOff      = 9'h000;
      st_next.hBlankCnt   = 8'h00;
      st_next.vBlankCnt   = 6'h00;
      st_next.pixelData   = 10'h000;
      st_next.hOut        = 1'b0;
      st_next.vOut        = 1'b0;
    end

    // integration window marked by the trigger
    if (!singleFrameMode) begin
      st_next.integ = 1'b0;
    end else if (trigRise) begin
      st_next.integ = 1'b1;
    end else if (trigFall) begin
      st_next.integ = 1'b0;
    end
  end

  // state register
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_reg            <= '0;
      st_reg.initSync   <= 2'h3;
      st_reg.saveSync   <= 2'h3;
      st_reg.freezeSync <= 2'h3;
      st_reg.sclSync    <= 2'h3;
      st_reg.sdaSync    <= 2'h3;
      st_reg.sclPrev    <= 1'b1;
      st_reg.sdaPrev    <= 1'b1;
      st_reg.i2cState   <= I2C_IDLE;
      st_reg.regs       <= REG_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // output drive
  assign sdaOut          = 1'b0;
  assign sdaDriveN       = ~st_reg.sdaDrive;
  assign pixelBus        = st_reg.pixelData;
  assign pixelClockOut   = st_reg.pixClk;
  assign hSyncOut        = st_reg.hOut;
  assign vSyncOut        = st_reg.vOut;
  assign badPixelEn      = st_reg.regs[IDX_MODE_A][BPR_BIT];
  assign darkAutoEn      = st_reg.regs[IDX_MODE_A][DLC_BIT];
  assign chanSeparateEn  = st_reg.regs[IDX_MODE_A][CCS_BIT];
  assign shutterEn       = st_reg.regs[IDX_MODE_A][SHUT_BIT];
  assign analogOffsetRef = st_reg.regs[IDX_OFFSET_REF];
  assign powerSaving     = ~st_reg.saveSync[1];
  assign integrating     = st_reg.integ;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  // checks
  property p_initRestores;
    !st_reg.initSync[1] |=> (st_reg.regs == REG_RESET) && badPixelEn == 1'b0 && adcRes == ADC_10BIT;
  endproperty
  a_initRestores: assert property (p_initRestores) else $error("registers not restored on chip init");

  property p_saveIdle;
    !st_reg.saveSync[1] |-> powerSaving ##1 (!pixelClockOut && pixelBus == 10'h000 && !hSyncOut && !vSyncOut);
  endproperty
  a_saveIdle: assert property (p_saveIdle) else $error("outputs active during power saving");

  property p_freezeHold;
    lineEndTick && st_reg.frameActive && !st_reg.freezeSync[1] && st_reg.saveSync[1]
      |=> st_reg.rowOff == $past(st_reg.rowOff) && st_reg.frameActive;
  endproperty
  a_freezeHold: assert property (p_freezeHold) else $error("row advanced while line frozen");

  property p_integrate;
    singleFrameMode && $past(singleFrameMode) && trigRise |=> integrating ##1 1'b1;
  endproperty
  a_integrate: assert property (p_integrate) else $error("integration did not start on trigger");

  property p_lsbZero;
    $past(adcRes) == ADC_8BIT && $past(pixTick) |-> pixelBus[1:0] == 2'h0;
  endproperty
  a_lsbZero: assert property (p_lsbZero) else $error("low pixel bits not zero at 8-bit");

  property p_div2Toggle;
    divCode == 2'h1 && $stable(divCode) && st_reg.saveSync[1] && pixelClockOut
      |=> !pixelClockOut ##1 pixelClockOut;
  endproperty
  a_div2Toggle: assert property (p_div2Toggle) else $error("pixel clock not half core clock");

  property p_hValid;
    $past(hDataValidMode) && $past(pixTick) && !hSyncOut |-> pixelBus == 10'h000;
  endproperty
  a_hValid: assert property (p_hValid) else $error("pixel data outside valid window");

  property p_vSync;
    !vLineValidMode && $past(vLineValidMode, 2) == 1'b0 && vSyncOut |-> pixelBus == 10'h000;
  endproperty
  a_vSync: assert property (p_vSync) else $error("pixel data during vertical sync");

  property p_ackDrive;
    $rose(st_reg.i2cState == I2C_ACK) |-> !sdaDriveN ##[1:1000] sdaDriveN;
  endproperty
  a_ackDrive: assert property (p_ackDrive) else $error("acknowledge not driven low");

  c_frameStart: cover property ($rose(st_reg.frameActive));
  c_readByte: cover property (st_reg.i2cState == I2C_TX ##1 st_reg.i2cState == I2C_TACK);
  c_regWrite: cover property (st_reg.i2cState == I2C_ACK && st_reg.byteKind == 2'h2);
  c_freeze: cover property (lineEndTick && !st_reg.freezeSync[1] && st_reg.frameActive);

endmodule  // image_sensor_readout_control

// ===== rtl/sensor_pkg.sv
package sensor_pkg;

  // register indices on the serial port
  localparam logic [7:0] IDX_MODE_A        = 8'h00;
  localparam logic [7:0] IDX_MODE_B        = 8'h01;
  localparam logic [7:0] IDX_ROW_START_HI  = 8'h02;
  localparam logic [7:0] IDX_ROW_START_LO  = 8'h03;
  localparam logic [7:0] IDX_COL_START_HI  = 8'h04;
  localparam logic [7:0] IDX_COL_START_LO  = 8'h05;
  localparam logic [7:0] IDX_ROWS_HI       = 8'h06;
  localparam logic [7:0] IDX_ROWS_LO       = 8'h07;
  localparam logic [7:0] IDX_COLS_HI       = 8'h08;
  localparam logic [7:0] IDX_COLS_LO       = 8'h09;
  localparam logic [7:0] IDX_OFFSET_REF    = 8'h0A;
  localparam logic [7:0] REG_COUNT         = 8'h0B;
  localparam int         NUM_REGS          = 11;

  // reset values and writable bits, index 0 in the low byte
  localparam logic [NUM_REGS-1:0][7:0] REG_RESET = {8'h80, 8'h80, 8'h02, 8'hE0, 8'h01, 8'h0E,
                                                    8'h00, 8'h0E, 8'h00, 8'h10, 8'h02};
  localparam logic [NUM_REGS-1:0][7:0] REG_MASK  = {8'hFF, 8'hFF, 8'h03, 8'hFF, 8'h01, 8'hFF,
                                                    8'h01, 8'hFF, 8'h01, 8'hFF, 8'h3F};

  // field positions, mode A
  localparam int BPR_BIT   = 5;
  localparam int DLC_BIT   = 4;
  localparam int CCS_BIT   = 3;
  localparam int SHUT_BIT  = 2;
  localparam int ADC_LSB   = 0;
  // field positions, mode B
  localparam int MIRV_BIT  = 7;
  localparam int MIRH_BIT  = 6;
  localparam int DIV_LSB   = 4;
  localparam int SUBR_LSB  = 2;
  localparam int SUBC_LSB  = 0;

  // conversion resolution codes
  localparam logic [1:0] ADC_8BIT  = 2'h0;
  localparam logic [1:0] ADC_9BIT  = 2'h1;
  localparam logic [1:0] ADC_10BIT = 2'h2;

  // frame timing in pixel ticks and lines
  localparam logic [7:0] HBLANK_LAST  = 8'h8B;
  localparam logic [7:0] HSYNC_TICKS  = 8'h20;
  localparam logic [5:0] VBLANK_LAST  = 6'h2C;
  localparam logic [5:0] VSYNC_LINES  = 6'h01;

  // serial slave address, value is arbitrary
  localparam logic [6:0] DEVICE_ADDR  = 7'h3C;

  typedef enum logic [4:0] {
    I2C_IDLE = 5'h01,
    I2C_RX   = 5'h02,
    I2C_ACK  = 5'h04,
    I2C_TX   = 5'h08,
    I2C_TACK = 5'h10
  } i2c_state_e;

endpackage

// ===== verification/host_pixel_sink.sv
`timescale 1ns/1ps

// host side: samples pixel bus and horizontal output on pixel clock rise
module host_pixel_sink (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       pixelClockOut,
  input  wire logic [9:0] pixelBus,
  input  wire logic       hSyncOut,
  output logic [9:0]      lastWord,
  output logic [7:0]      clkPeriod,
  output logic [7:0]      hLen
);
  logic       clkPrev;
  logic [7:0] gap;
  logic [7:0] hCnt;

  // period, last nonzero word, length of each horizontal pulse
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      clkPrev   <= 1'b0;
      gap       <= 8'h00;
      clkPeriod <= 8'h00;
      lastWord  <= 10'h000;
      hCnt      <= 8'h00;
      hLen      <= 8'h00;
    end else begin
      clkPrev <= pixelClockOut;
      gap     <= gap + 8'h01;
      if (pixelClockOut && !clkPrev) begin
        gap       <= 8'h01;
        clkPeriod <= gap;
        if (pixelBus != 10'h000) lastWord <= pixelBus;
        if (hSyncOut) hCnt <= hCnt + 8'h01;
        else if (hCnt != 8'h00) begin
          hLen <= hCnt;
          hCnt <= 8'h00;
        end
      end
    end
  end
endmodule  // host_pixel_sink

// ===== verification/image_sensor_readout_control_tb_top.sv
`timescale 1ns/1ps

module image_sensor_readout_control_tb_top;
  import sensor_pkg::*;
  logic       core_clk = 1'b0, reset = 1'b1, chipInitN = 1'b1, powerSaveN = 1'b1;
  logic       integrationTrigger = 1'b0, singleFrameMode = 1'b0, hDataValidMode = 1'b0;
  logic       sclIn = 1'b1, hostSda = 1'b1, lineFreezeN = 1'b1;
  logic [9:0] arrayRow, rowHeld;
  logic       sdaOut, sdaDriveN, pixelClockOut, hSyncOut, vSyncOut, powerSaving, integrating;
  logic       badPixelEn, darkAutoEn, chanSeparateEn, shutterEn;
  logic [9:0] pixelBus, lastWord;
  logic [7:0] analogOffsetRef, clkPeriod, hLen;
  logic [9:0] resWord [3] = '{10'h3FC, 10'h3FE, 10'h3FF};
  wire        sdaWire;
  int         badCount = 0, samplesChecked = 0;

  // pull-up on the data line, device pulls low when enabled
  assign sdaWire = sdaDriveN ? hostSda : sdaOut;
  always #50 core_clk = ~core_clk;

  image_sensor_readout_control i_image_sensor_readout_control (
    .core_clk(core_clk), .reset(reset), .chipInitN(chipInitN), .powerSaveN(powerSaveN),
    .lineFreezeN(lineFreezeN), .integrationTrigger(integrationTrigger), .singleFrameMode(singleFrameMode),
    .hDataValidMode(hDataValidMode), .vLineValidMode(1'b0), .pixelIn(10'h3FF), .sclIn(sclIn),
    .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaDriveN(sdaDriveN), .pixelBus(pixelBus),
    .pixelClockOut(pixelClockOut), .hSyncOut(hSyncOut), .vSyncOut(vSyncOut), .arrayRow(arrayRow), .arrayCol(),
    .badPixelEn(badPixelEn), .darkAutoEn(darkAutoEn), .chanSeparateEn(chanSeparateEn),
    .shutterEn(shutterEn), .analogOffsetRef(analogOffsetRef), .powerSaving(powerSaving),
    .integrating(integrating));

  host_pixel_sink i_host_pixel_sink (
    .core_clk(core_clk), .reset(reset), .pixelClockOut(pixelClockOut), .pixelBus(pixelBus),
    .hSyncOut(hSyncOut), .lastWord(lastWord), .clkPeriod(clkPeriod), .hLen(hLen));

  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      badCount++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // serial bit: data changes mid low phase, held through high phase
  task automatic sbit(input logic b);
    sclIn = 1'b0;
    tick(3);
    hostSda = b;
    tick(3);
    sclIn = 1'b1;
    tick(6);
  endtask

  task automatic rbit(output logic b);
    sclIn = 1'b0;
    tick(3);
    hostSda = 1'b1;
    tick(3);
    sclIn = 1'b1;
    tick(3);
    b = sdaWire;
    tick(3);
  endtask

  // start is (1,0), stop is (0,1): data edge while clock high
  task automatic cond(input logic first, input logic last);
    sclIn = 1'b0;
    tick(3);
    hostSda = first;
    tick(3);
    sclIn = 1'b1;
    tick(6);
    hostSda = last;
    tick(6);
  endtask

  task automatic sbyte(input logic [7:0] v, input logic ackExp);
    logic a;
    for (int i = 7; i >= 0; i--) sbit(v[i]);
    rbit(a);
    chk({15'h0000, a}, {15'h0000, ackExp});
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cond(1'b1, 1'b0);
    sbyte({DEVICE_ADDR, 1'b0}, 1'b0);
    sbyte(a, 1'b0);
    sbyte(d, 1'b0);
    cond(1'b0, 1'b1);
  endtask

  // pointer write, repeated start, one byte read with final nack
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    cond(1'b1, 1'b0);
    sbyte({DEVICE_ADDR, 1'b0}, 1'b0);
    sbyte(a, 1'b0);
    cond(1'b1, 1'b0);
    sbyte({DEVICE_ADDR, 1'b1}, 1'b0);
    for (int i = 7; i >= 0; i--) rbit(d[i]);
    sbit(1'b1);
    cond(1'b0, 1'b1);
    chk({8'h00, d}, {8'h00, e});
  endtask

  task automatic closeOut;
    $display("comparisons %0d, mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // main sequence
  initial begin
    tick(6);
    reset = 1'b0;
    tick(4);
    for (int i = 0; i < NUM_REGS; i++) rchk(8'(i), REG_RESET[i]);
    chk({12'h000, badPixelEn, darkAutoEn, chanSeparateEn, shutterEn}, 16'h0000);
    for (int i = 0; i < NUM_REGS; i++) wr(8'(i), 8'hFF);
    for (int i = 0; i < NUM_REGS; i++) rchk(8'(i), REG_MASK[i]);
    chk({12'h000, badPixelEn, darkAutoEn, chanSeparateEn, shutterEn}, 16'h000F);
    chk({8'h00, analogOffsetRef}, 16'h00FF);
    rchk(8'h0B, 8'h00);
    cond(1'b1, 1'b0);
    sbyte({~DEVICE_ADDR, 1'b0}, 1'b1);
    cond(1'b0, 1'b1);
    chipInitN = 1'b0;
    tick(8);
    chipInitN = 1'b1;
    tick(4);
    for (int i = 0; i < NUM_REGS; i++) rchk(8'(i), REG_RESET[i]);
    wr(IDX_ROWS_HI, 8'h00);
    wr(IDX_ROWS_LO, 8'h02);
    wr(IDX_COLS_HI, 8'h00);
    wr(IDX_COLS_LO, 8'h04);
    hDataValidMode = 1'b1;
    for (int r = 0; r < 3; r++) begin
      wr(IDX_MODE_A, 8'(r));
      tick(14000);
      chk({6'h00, lastWord}, {6'h00, resWord[r]});
      chk({8'h00, hLen}, 16'h0004);
    end
    lineFreezeN = 1'b0;
    wr(IDX_MODE_B, 8'h11);
    tick(14000);
    chk({8'h00, hLen}, 16'h0002);
    rowHeld = arrayRow;
    hDataValidMode = 1'b0;
    tick(600);
    chk({8'h00, hLen}, 16'h0020);
    chk({6'h00, arrayRow}, {6'h00, rowHeld});
    lineFreezeN = 1'b1;
    for (int d = 1; d < 4; d++) begin
      wr(IDX_MODE_B, {2'b00, 2'(d), 4'h0});
      tick(40);
      chk({8'h00, clkPeriod}, 16'h0001 << d);
    end
    wr(IDX_MODE_B, 8'h00);
    tick(20);
    chk({15'h0000, pixelClockOut}, 16'h0001);
    powerSaveN = 1'b0;
    tick(6);
    chk({5'h00, powerSaving, pixelBus}, 16'h0400);
    powerSaveN = 1'b1;
    tick(6);
    chk({15'h0000, powerSaving}, 16'h0000);
    singleFrameMode = 1'b1;
    integrationTrigger = 1'b1;
    tick(6);
    chk({15'h0000, integrating}, 16'h0001);
    integrationTrigger = 1'b0;
    tick(6);
    chk({15'h0000, integrating}, 16'h0000);
    closeOut();
  end
endmodule  // image_sensor_readout_control_tb_top
